// >>> sim/tb.sv
// Purpose: self-checking bench of the channel control block
// Assumes: flow codes left at reset values
// Notes:   random stimulus from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ucl_pkg::*;
   ucl_bus_req_t bus_req;
   ucl_modem_t   modem_in_n, pins_cmd;
   logic [7:0]   rd_data, rx_char, v, s, c;
   logic [3:0]   char_bits, m;
   logic [1:0]   e;
   logic         mclk, sys_rst, irq, serial_rx_pin, serial_tx_pin, rx_cmd;
   logic         dtr_n, rts_n, aux_pin, rx_ready, tsr_out, rsr_in, h;
   logic         rx_char_valid, rx_store, tx_halted, prediv_tick;
   int           seed = 89009;
   int           err_total = 0;
   int           check_count = 0;
   int           n;
   ucl_channel i_ucl_channel (
      .mclk, .sys_rst, .bus_req, .rd_data, .irq, .serial_rx_pin,
      .serial_tx_pin, .modem_in_n, .dtr_n, .rts_n, .aux_pin,
      .receive_ready_signal(rx_ready), .tsr_out, .rsr_in, .rx_char_valid,
      .rx_char, .rx_store, .tx_halted, .char_bits, .prediv_tick
   );
   ucl_modem_peer i_ucl_modem_peer (
      .mclk, .pins_cmd, .rx_cmd, .modem_in_n, .serial_rx_pin
   );
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // ==========
   // helpers
   function automatic logic [3:0] loop_stat(input logic [3:0] b);
      return {b[UCL_MC_AUX2], b[UCL_MC_AUX1], b[UCL_MC_DTR], b[UCL_MC_RTS]};
   endfunction : loop_stat
   function automatic logic [1:0] flow_exp(input logic hl,
                                           input logic [7:0] ch,
                                           input logic any);
      if (ch == UCL_RST_PAUSE)
         return 2'b10;
      if (ch == UCL_RST_RESUME)
         return 2'b00;
      return {hl && !any, 1'b1};
   endfunction : flow_exp
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      bus_req.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge mclk);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      bus_req.rd <= 1'b0;
      @(negedge mclk);
      d = rd_data;
   endtask : rd
   task automatic look(input int k);
      repeat (k) @(posedge mclk);
      @(negedge mclk);
   endtask : look
   task automatic send(input logic [7:0] ch, input logic [1:0] ex);
      @(posedge mclk);
      rx_char_valid <= 1'b1;
      rx_char       <= ch;
      @(posedge mclk);
      rx_char_valid <= 1'b0;
      @(negedge mclk);
      check({6'h0, tx_halted, rx_store}, {6'h0, ex});
   endtask : send
   task automatic finish_test;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : finish_test
   initial begin
      #600000;
      err_total++;
      finish_test();
   end
   // ==========
   // scenarios
   initial begin
      sys_rst       = 1'b1;
      bus_req       = '0;
      pins_cmd      = '1;
      rx_cmd        = 1'b1;
      rx_ready      = 1'b0;
      tsr_out       = 1'b1;
      rx_char_valid = 1'b0;
      rx_char       = 8'h00;
      repeat (4) @(posedge mclk);
      sys_rst <= 1'b0;
      rd(UCL_ADDR_MODEM_CONTROL, v);
      check(v, UCL_RST_BYTE);
      wr(4'h1, 8'hff);
      rd(4'h1, v);
      check(v, 8'h00);
      check({4'h0, char_bits}, 8'h05);
      check({7'h0, aux_pin}, 8'h01);
      for (int i = 0; i < 4; i++) begin
         wr(UCL_ADDR_LINE_CONTROL, (8'($random(seed)) & 8'hfc) | 8'(i));
         look(2);
         check({4'h0, char_bits}, 8'(5 + i));
         rd(UCL_ADDR_LINE_CONTROL, v);
         check({6'h0, v[1:0]}, 8'(i));
      end
      for (int d = 0; d < 2; d++) begin
         wr(UCL_ADDR_MODEM_CONTROL, {d[0], 7'h00});
         look(8);
         n = 0;
         repeat (16) begin
            @(negedge mclk);
            n += int'(prediv_tick);
         end
         check(8'(n), (d == 1) ? 8'h04 : 8'h10);
      end
      wr(UCL_ADDR_MODEM_CONTROL, 8'h40);
      look(10);
      check({6'h0, serial_tx_pin, rsr_in}, 8'h00);
      wr(UCL_ADDR_MODEM_CONTROL, 8'h08);
      look(10);
      check({7'h0, serial_tx_pin, aux_pin}, 8'h02);
      wr(UCL_ADDR_PIN_FUNC, 8'h02);
      repeat (4) begin
         @(posedge mclk);
         rx_ready <= 1'($random(seed));
         look(2);
         check({7'h0, aux_pin}, {7'h0, rx_ready});
      end
      wr(UCL_ADDR_PIN_FUNC, 8'h01);
      look(2);
      h = aux_pin;
      look(0);
      check({7'h0, aux_pin}, {7'h0, !h});
      wr(UCL_ADDR_PIN_FUNC, 8'h03);
      rd(UCL_ADDR_PIN_FUNC, v);
      check(v, 8'h00);
      check({7'h0, aux_pin}, 8'h00);
      wr(UCL_ADDR_INT_MASK, 8'h01);
      wr(UCL_ADDR_MODEM_CONTROL, 8'h10);
      look(8);
      wr(UCL_ADDR_INT_STATUS, 8'hff);
      m = 4'h0;
      repeat (6) begin
         v = 8'($random(seed));
         @(posedge mclk);
         pins_cmd <= ucl_modem_t'(v[7:4]);
         rx_cmd   <= v[7];
         tsr_out  <= v[6];
         wr(UCL_ADDR_MODEM_CONTROL, {4'h1, v[3:0]});
         look(6);
         check({6'h0, serial_tx_pin, rsr_in}, {6'h0, 1'b1, v[6]});
         check({6'h0, dtr_n, rts_n}, 8'h03);
         check({7'h0, irq}, {7'h0, v[3:0] != m});
         rd(UCL_ADDR_MODEM_STATUS, s);
         check({4'h0, s[7:4]}, {4'h0, loop_stat(v[3:0])});
         c = {4'h0, loop_stat(v[3:0]) ^ loop_stat(m)};
         check({4'h0, s[3:0]}, c);
         wr(UCL_ADDR_INT_STATUS, 8'h01);
         look(2);
         check({7'h0, irq}, 8'h00);
         m = v[3:0];
      end
      wr(UCL_ADDR_INT_MASK, 8'h00);
      wr(UCL_ADDR_MODEM_CONTROL, {4'h1, ~m});
      look(4);
      rd(UCL_ADDR_INT_STATUS, s);
      check({6'h0, irq, s[0]}, 8'h01);
      repeat (3) begin
         v = 8'($random(seed));
         @(posedge mclk);
         pins_cmd <= ucl_modem_t'(v[7:4]);
         rx_cmd   <= v[0];
         wr(UCL_ADDR_MODEM_CONTROL, {6'h0, v[1:0]});
         look(6);
         rd(UCL_ADDR_MODEM_STATUS, s);
         check({4'h0, s[7:4]}, {4'h0, ~v[7:4]});
         check({6'h0, rts_n, dtr_n}, {6'h0, ~v[1:0]});
         check({7'h0, rsr_in}, {7'h0, v[0]});
      end
      wr(UCL_ADDR_FLOW_CTRL, 8'h01);
      wr(UCL_ADDR_MODEM_CONTROL, 8'h20);
      wr(UCL_ADDR_INT_STATUS, 8'hff);
      look(8);
      h = 1'b0;
      for (int i = 0; i < 24; i++) begin
         n = {$random(seed)} % 4;
         c = (n == 0) ? UCL_RST_PAUSE : (n == 1) ? UCL_RST_RESUME
                                                 : 8'($random(seed));
         if (i == 12) begin
            wr(UCL_ADDR_MODEM_CONTROL, 8'h00);
            look(8);
         end
         e = flow_exp(h, c, i < 12);
         send(c, e);
         h = e[1];
      end
      rd(UCL_ADDR_INT_STATUS, s);
      check({6'h0, s[2:1]}, 8'h03);
      wr(UCL_ADDR_FLOW_CTRL, 8'h00);
      look(8);
      send(UCL_RST_PAUSE, 2'b01);
      finish_test();
   end
endmodule : tb
`default_nettype wire

// >>> sim/ucl_channel_properties.sv
// Purpose: port assertions of the channel control block
// Assumes: flow codes stay at their reset values
// Notes:   most checks wait until register writes have settled
`timescale 1ns/1ps
`default_nettype none
module ucl_channel_props
   import ucl_pkg::*;
(
   input wire logic                  mclk,
   input wire logic                  sys_rst,
   input wire ucl_pkg::ucl_bus_req_t bus_req,
   input wire logic [7:0]            rd_data,
   input wire logic                  irq,
   input wire logic                  serial_rx_pin,
   input wire logic                  serial_tx_pin,
   input wire ucl_pkg::ucl_modem_t   modem_in_n,
   input wire logic                  dtr_n,
   input wire logic                  rts_n,
   input wire logic                  aux_pin,
   input wire logic                  receive_ready_signal,
   input wire logic                  tsr_out,
   input wire logic                  rsr_in,
   input wire logic                  rx_char_valid,
   input wire logic [7:0]            rx_char,
   input wire logic                  rx_store,
   input wire logic                  tx_halted,
   input wire logic [3:0]            char_bits,
   input wire logic                  prediv_tick
);
   import ucl_pkg::*;
   // ==========
   // shadow of written configuration
   logic [7:0] mc_reg, mc_next;
   logic [1:0] pf_reg, pf_next;
   logic [3:0] age_reg, age_next;
   logic       fc_reg, fc_next, quiet, w_lcr, code, loop;
   assign w_lcr = bus_req.wr && bus_req.addr == UCL_ADDR_LINE_CONTROL;
   assign quiet = age_reg[3];
   assign loop  = mc_reg[UCL_MC_LOOP];
   assign code  = rx_char == UCL_RST_PAUSE || rx_char == UCL_RST_RESUME;
   always_comb begin
      mc_next  = mc_reg;
      fc_next  = fc_reg;
      pf_next  = pf_reg;
      age_next = age_reg + {3'h0, !quiet};
      if (bus_req.wr) begin
         age_next = 4'h0;
         case (bus_req.addr)
            UCL_ADDR_MODEM_CONTROL: mc_next = bus_req.wdata;
            UCL_ADDR_FLOW_CTRL:     fc_next = bus_req.wdata[UCL_FC_EN];
            UCL_ADDR_PIN_FUNC:
               pf_next = &bus_req.wdata[1:0] ? 2'h0 : bus_req.wdata[1:0];
            default: ;
         endcase
      end
   end
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         mc_reg  <= UCL_RST_BYTE;
         fc_reg  <= 1'b0;
         pf_reg  <= 2'h0;
         age_reg <= 4'h0;
      end else begin
         mc_reg  <= mc_next;
         fc_reg  <= fc_next;
         pf_reg  <= pf_next;
         age_reg <= age_next;
      end
   end
   // ==========
   // assertions
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   a_char_length: assert property (
      w_lcr ##1 !w_lcr |=>
      char_bits == 4'h5 + {2'h0, $past(bus_req.wdata[1:0], 2)})
      else $error("word length mismatch");
   a_div4_rate: assert property (
      quiet && mc_reg[UCL_MC_DIV4] && prediv_tick |=>
      !prediv_tick [*3] ##1 prediv_tick)
      else $error("divide by four rate wrong");
   a_div1_rate: assert property (
      quiet && !mc_reg[UCL_MC_DIV4] |-> prediv_tick)
      else $error("divide by one tick missing");
   a_loop_mark: assert property (
      quiet && loop |-> serial_tx_pin)
      else $error("serial output not at mark in loopback");
   a_loop_pins: assert property (
      quiet && loop |-> dtr_n && rts_n && (aux_pin || pf_reg != 2'h0))
      else $error("modem outputs not inactive in loopback");
   a_ctrl_pins: assert property (
      quiet && !loop |-> {rts_n, dtr_n} == ~mc_reg[1:0])
      else $error("modem outputs do not follow control bits");
   a_aux_level: assert property (
      quiet && !loop && pf_reg == 2'h0 |-> aux_pin == !mc_reg[UCL_MC_AUX2])
      else $error("aux pin does not follow control bit");
   a_pause_halts: assert property (
      quiet && fc_reg && rx_char_valid && rx_char == UCL_RST_PAUSE |=>
      tx_halted && !rx_store)
      else $error("pause code did not halt");
   a_any_resumes: assert property (
      quiet && fc_reg && mc_reg[UCL_MC_ANY] && tx_halted && rx_char_valid
      && !code |=> !tx_halted && rx_store)
      else $error("any character did not resume and store");
   a_flow_off: assert property (
      quiet && !fc_reg && rx_char_valid |=> rx_store && !tx_halted)
      else $error("flow off character not stored");
endmodule : ucl_channel_props
bind ucl_channel ucl_channel_props i_ucl_channel_props (
   .mclk, .sys_rst, .bus_req, .rd_data, .irq, .serial_rx_pin,
   .serial_tx_pin, .modem_in_n, .dtr_n, .rts_n, .aux_pin,
   .receive_ready_signal, .tsr_out, .rsr_in, .rx_char_valid, .rx_char,
   .rx_store, .tx_halted, .char_bits, .prediv_tick
);
`default_nettype wire

// >>> sim/ucl_modem_peer.sv
// Purpose: modem side model, drives status pins and receive line
// Assumes: the bench commands pin levels
// Notes:   pins change just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module ucl_modem_peer
   import ucl_pkg::*;
(
   input  wire logic                mclk,
   input  wire ucl_pkg::ucl_modem_t pins_cmd,
   input  wire logic                rx_cmd,
   output var  ucl_pkg::ucl_modem_t modem_in_n,
   output var  logic                serial_rx_pin
);
   import ucl_pkg::*;
   always @(posedge mclk) begin
      modem_in_n    <= pins_cmd;
      serial_rx_pin <= rx_cmd;
   end
endmodule : ucl_modem_peer
`default_nettype wire

// >>> src/ucl_channel.sv
// Purpose: per-channel line and modem control of a serial port
// Assumes: transmitter, receiver and fifo sit outside on mclk
// Notes:   modem pins are active low; all outputs registered
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module ucl_channel
   import ucl_pkg::*;
(
   input  wire logic                  mclk,
   input  wire logic                  sys_rst,
   input  wire ucl_pkg::ucl_bus_req_t bus_req,
   output var  logic [7:0]            rd_data,
   output var  logic                  irq,
   input  wire logic                  serial_rx_pin,
   output var  logic                  serial_tx_pin,
   input  wire ucl_pkg::ucl_modem_t   modem_in_n,
   output var  logic                  dtr_n,
   output var  logic                  rts_n,
   output var  logic                  aux_pin,
   input  wire logic                  receive_ready_signal,
   input  wire logic                  tsr_out,
   output var  logic                  rsr_in,
   input  wire logic                  rx_char_valid,
   input  wire logic [7:0]            rx_char,
   output var  logic                  rx_store,
   output var  logic                  tx_halted,
   output var  logic [3:0]            char_bits,
   output var  logic                  prediv_tick
);
   import ucl_pkg::*;

   logic [7:0]           line_control_reg, line_control_next;
   logic [7:0]           modem_control_reg, modem_control_next;
   logic [7:0]           pause_code_reg, pause_code_next;
   logic [7:0]           resume_code_reg, resume_code_next;
   logic                 flow_en_reg, flow_en_next;
   ucl_pin_func_t        pin_func_reg, pin_func_next;
   logic [UCL_INT_W-1:0] int_status_reg, int_status_next;
   logic [UCL_INT_W-1:0] int_mask_reg, int_mask_next;
   logic [7:0]           rd_next;
   logic                 irq_next;
   logic [3:0]           delta_reg, delta_next;
   ucl_modem_t           state_reg, state_next;
   ucl_modem_t           state_src;
   ucl_modem_t           pins_sync;
   logic [0:0]           rx_sync;
   logic                 halt_next, store_next;
   logic                 resume_ev, halt_ev;
   logic                 tx_next, rsr_next;
   logic                 dtr_next, rts_next, aux_next;
   logic                 baud_reg, baud_next;
   logic [3:0]           bits_next;
   logic                 loop;
   logic                 div_tick;
   logic                 ir_pulse_reg, ir_pulse_next;
   logic                 loop_reg, loop_next;
   logic                 wr_hit_status;

   // ==========================================================
   // input synchronisers and pre-divider
   ucl_sync #(.W(4)) u_modem_sync (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .d_async (modem_in_n),
      .rst_val (4'hf),
      .q_sync  (pins_sync)
   );
   ucl_sync #(.W(1)) u_rx_sync (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .d_async (serial_rx_pin),
      .rst_val (1'b1),
      .q_sync  (rx_sync)
   );
   ucl_prediv u_prediv (
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .div4_sel (modem_control_reg[UCL_MC_DIV4]),
      .div_tick (div_tick)
   );

   // ==========================================================
   // register file
   assign wr_hit_status = bus_req.wr && bus_req.addr == UCL_ADDR_INT_STATUS;
   always_comb begin
      line_control_next  = line_control_reg;
      modem_control_next = modem_control_reg;
      pause_code_next    = pause_code_reg;
      resume_code_next   = resume_code_reg;
      flow_en_next       = flow_en_reg;
      pin_func_next      = pin_func_reg;
      int_mask_next      = int_mask_reg;
      rd_next            = UCL_RST_BYTE;
      if (bus_req.wr) begin
         if (bus_req.addr == UCL_ADDR_LINE_CONTROL) begin
            line_control_next = bus_req.wdata;
         end else if (bus_req.addr == UCL_ADDR_MODEM_CONTROL) begin
            modem_control_next = bus_req.wdata;
         end else if (bus_req.addr == UCL_ADDR_INT_MASK) begin
            int_mask_next = bus_req.wdata[UCL_INT_W-1:0];
         end else if (bus_req.addr == UCL_ADDR_PAUSE_CODE) begin
            pause_code_next = bus_req.wdata;
         end else if (bus_req.addr == UCL_ADDR_RESUME_CODE) begin
            resume_code_next = bus_req.wdata;
         end else if (bus_req.addr == UCL_ADDR_FLOW_CTRL) begin
            flow_en_next = bus_req.wdata[UCL_FC_EN];
         end else if (bus_req.addr == UCL_ADDR_PIN_FUNC) begin
            pin_func_next = (bus_req.wdata[1:0] == 2'h3) ?
                            UCL_PIN_AUX : ucl_pin_func_t'(bus_req.wdata[1:0]);
         end
      end
      if (bus_req.rd) begin
         if (bus_req.addr == UCL_ADDR_LINE_CONTROL) begin
            rd_next = line_control_reg;
         end else if (bus_req.addr == UCL_ADDR_MODEM_CONTROL) begin
            rd_next = modem_control_reg;
         end else if (bus_req.addr == UCL_ADDR_MODEM_STATUS) begin
            rd_next = {state_reg.dcd, state_reg.ri, state_reg.dsr,
                       state_reg.cts, delta_reg};
         end else if (bus_req.addr == UCL_ADDR_INT_STATUS) begin
            rd_next = {5'h00, int_status_reg};
         end else if (bus_req.addr == UCL_ADDR_INT_MASK) begin
            rd_next = {5'h00, int_mask_reg};
         end else if (bus_req.addr == UCL_ADDR_PAUSE_CODE) begin
            rd_next = pause_code_reg;
         end else if (bus_req.addr == UCL_ADDR_RESUME_CODE) begin
            rd_next = resume_code_reg;
         end else if (bus_req.addr == UCL_ADDR_FLOW_CTRL) begin
            rd_next = {7'h00, flow_en_reg};
         end else if (bus_req.addr == UCL_ADDR_PIN_FUNC) begin
            rd_next = {6'h00, pin_func_reg};
         end
      end
      if (sys_rst) begin
         line_control_next  = UCL_RST_BYTE;
         modem_control_next = UCL_RST_BYTE;
         pause_code_next    = UCL_RST_PAUSE;
         resume_code_next   = UCL_RST_RESUME;
         flow_en_next       = 1'b0;
         pin_func_next      = UCL_PIN_AUX;
         int_mask_next      = '0;
         rd_next            = UCL_RST_BYTE;
      end
   end
   always_ff @(posedge mclk) begin
      line_control_reg  <= line_control_next;
      modem_control_reg <= modem_control_next;
      pause_code_reg    <= pause_code_next;
      resume_code_reg   <= resume_code_next;
      flow_en_reg       <= flow_en_next;
      pin_func_reg      <= pin_func_next;
      int_mask_reg      <= int_mask_next;
      rd_data           <= rd_next;
   end

   // ==========================================================
   // software flow control with resume on any character
   always_comb begin
      halt_ev    = 1'b0;
      resume_ev  = 1'b0;
      halt_next  = tx_halted;
      store_next = rx_char_valid;
      if (rx_char_valid && flow_en_reg) begin
         if (rx_char == pause_code_reg) begin
            halt_ev    = !tx_halted;
            halt_next  = 1'b1;
            store_next = 1'b0;
         end else if (rx_char == resume_code_reg) begin
            resume_ev  = tx_halted;
            halt_next  = 1'b0;
            store_next = 1'b0;
         end else if (tx_halted && modem_control_reg[UCL_MC_ANY]) begin
            resume_ev  = 1'b1;
            halt_next  = 1'b0;
            store_next = 1'b1;
         end
      end
      if (!flow_en_reg) begin
         halt_next = 1'b0;
      end
      if (sys_rst) begin
         halt_next  = 1'b0;
         store_next = 1'b0;
      end
   end
   always_ff @(posedge mclk) begin
      tx_halted <= halt_next;
      rx_store  <= store_next;
   end

   // ==========================================================
   // modem status, delta bits
   assign loop = modem_control_reg[UCL_MC_LOOP];
   always_comb begin
      if (loop) begin
         state_src.cts = modem_control_reg[UCL_MC_RTS];
         state_src.dsr = modem_control_reg[UCL_MC_DTR];
         state_src.ri  = modem_control_reg[UCL_MC_AUX1];
         state_src.dcd = modem_control_reg[UCL_MC_AUX2];
      end else begin
         state_src = ~pins_sync;
      end
      state_next = state_src;
      delta_next = delta_reg | (state_src ^ state_reg);
      if (bus_req.rd && bus_req.addr == UCL_ADDR_MODEM_STATUS) begin
         delta_next = state_src ^ state_reg;
      end
      if (sys_rst) begin
         state_next = '0;
         delta_next = 4'h0;
      end
   end
   always_ff @(posedge mclk) begin
      state_reg <= state_next;
      delta_reg <= delta_next;
   end

   // ==========================================================
   // interrupt status and output
   always_comb begin
      int_status_next = int_status_reg;
      if (wr_hit_status) begin
         int_status_next = int_status_reg & ~bus_req.wdata[UCL_INT_W-1:0];
      end
      if (|(state_src ^ state_reg)) begin
         int_status_next[UCL_INT_MODEM] = 1'b1;
      end
      if (resume_ev) begin
         int_status_next[UCL_INT_RESUME] = 1'b1;
      end
      if (halt_ev) begin
         int_status_next[UCL_INT_HALT] = 1'b1;
      end
      irq_next = |(int_status_next & int_mask_reg);
      if (sys_rst) begin
         int_status_next = '0;
         irq_next        = 1'b0;
      end
   end
   always_ff @(posedge mclk) begin
      int_status_reg <= int_status_next;
      irq            <= irq_next;
   end

   // ==========================================================
   // serial path, modem pins, aux pin, baud clock
   always_comb begin
      loop_next     = loop_reg;
      baud_next     = baud_reg;
      ir_pulse_next = 1'b0;
      if (div_tick) begin
         loop_next     = loop;
         baud_next     = !baud_reg;
         ir_pulse_next = !baud_reg;
      end
      if (loop_reg) begin
         tx_next  = 1'b1;
         rsr_next = tsr_out;
      end else if (modem_control_reg[UCL_MC_IR]) begin
         tx_next  = !tsr_out && ir_pulse_reg;
         rsr_next = !rx_sync[0];
      end else begin
         tx_next  = tsr_out;
         rsr_next = rx_sync[0];
      end
      dtr_next = loop || !modem_control_reg[UCL_MC_DTR];
      rts_next = loop || !modem_control_reg[UCL_MC_RTS];
      if (pin_func_reg == UCL_PIN_BAUD) begin
         aux_next = baud_reg;
      end else if (pin_func_reg == UCL_PIN_RXRDY) begin
         aux_next = receive_ready_signal;
      end else begin
         aux_next = loop || !modem_control_reg[UCL_MC_AUX2];
      end
      bits_next = UCL_BITS_BASE + {2'h0, line_control_reg[1:0]};
      if (sys_rst) begin
         loop_next     = 1'b0;
         baud_next     = 1'b0;
         ir_pulse_next = 1'b0;
         tx_next       = 1'b1;
         rsr_next      = 1'b1;
         dtr_next      = 1'b1;
         rts_next      = 1'b1;
         aux_next      = 1'b1;
         bits_next     = UCL_BITS_BASE;
      end
   end
   always_ff @(posedge mclk) begin
      loop_reg      <= loop_next;
      baud_reg      <= baud_next;
      ir_pulse_reg  <= ir_pulse_next;
      serial_tx_pin <= tx_next;
      rsr_in        <= rsr_next;
      dtr_n         <= dtr_next;
      rts_n         <= rts_next;
      aux_pin       <= aux_next;
      char_bits     <= bits_next;
      prediv_tick   <= div_tick && !sys_rst;
   end
endmodule : ucl_channel
`default_nettype wire

// >>> src/ucl_pkg.sv
// Purpose: shared constants and types of the channel control block
// Assumes: one 10 MHz clock, plain register port
// Notes:   offsets are byte indices on the register port
package ucl_pkg;
   // ==========================================================
   // register map
   localparam logic [3:0] UCL_ADDR_LINE_CONTROL  = 4'h3;
   localparam logic [3:0] UCL_ADDR_MODEM_CONTROL = 4'h4;
   localparam logic [3:0] UCL_ADDR_MODEM_STATUS  = 4'h6;
   localparam logic [3:0] UCL_ADDR_INT_STATUS    = 4'h8;
   localparam logic [3:0] UCL_ADDR_INT_MASK      = 4'h9;
   localparam logic [3:0] UCL_ADDR_PAUSE_CODE    = 4'ha;
   localparam logic [3:0] UCL_ADDR_RESUME_CODE   = 4'hb;
   localparam logic [3:0] UCL_ADDR_FLOW_CTRL     = 4'hc;
   localparam logic [3:0] UCL_ADDR_PIN_FUNC      = 4'hd;
   // ==========================================================
   // reset values
   localparam logic [7:0] UCL_RST_BYTE   = 8'h00;
   localparam logic [7:0] UCL_RST_PAUSE  = 8'h13;
   localparam logic [7:0] UCL_RST_RESUME = 8'h11;
   // ==========================================================
   // field positions
   localparam int UCL_MC_DIV4   = 7;
   localparam int UCL_MC_IR     = 6;
   localparam int UCL_MC_ANY    = 5;
   localparam int UCL_MC_LOOP   = 4;
   localparam int UCL_MC_AUX2   = 3;
   localparam int UCL_MC_AUX1   = 2;
   localparam int UCL_MC_RTS    = 1;
   localparam int UCL_MC_DTR    = 0;
   localparam int UCL_FC_EN     = 0;
   localparam int UCL_INT_MODEM = 0;
   localparam int UCL_INT_RESUME = 1;
   localparam int UCL_INT_HALT  = 2;
   localparam int UCL_INT_W     = 3;
   localparam logic [3:0] UCL_BITS_BASE = 4'h5;
   // ==========================================================
   // pre-divider
   localparam logic [1:0] UCL_DIV4_LAST = 2'h3;
   localparam logic [1:0] UCL_DIV1_LAST = 2'h0;
   // ==========================================================
   // types
   typedef enum logic [1:0] {
      UCL_PIN_AUX, UCL_PIN_BAUD, UCL_PIN_RXRDY
   } ucl_pin_func_t;
   typedef struct packed {
      logic dcd;
      logic ri;
      logic dsr;
      logic cts;
   } ucl_modem_t;
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } ucl_bus_req_t;
endpackage : ucl_pkg

// >>> src/ucl_prediv.sv
// Purpose: divide-by-1 or divide-by-4 pre-divider
// Assumes: ratio select from the same clock domain
// Notes:   ratio is taken only at a divided edge
`timescale 1ns/1ps
`default_nettype none
module ucl_prediv
   import ucl_pkg::*;
(
   input  wire logic mclk,
   input  wire logic sys_rst,
   input  wire logic div4_sel,
   output var  logic div_tick
);
   import ucl_pkg::*;
   logic [1:0] cnt_reg;
   logic [1:0] cnt_next;
   logic [1:0] last_reg;
   logic [1:0] last_next;
   logic       tick_next;
   // ==========================================================
   // counter, ratio latched at wrap
   always_comb begin
      tick_next = (cnt_reg == last_reg);
      cnt_next  = tick_next ? 2'h0 : cnt_reg + 2'h1;
      last_next = last_reg;
      if (tick_next) begin
         last_next = div4_sel ? UCL_DIV4_LAST : UCL_DIV1_LAST;
      end
      if (sys_rst) begin
         cnt_next  = 2'h0;
         last_next = UCL_DIV1_LAST;
         tick_next = 1'b0;
      end
   end
   always_ff @(posedge mclk) begin
      cnt_reg  <= cnt_next;
      last_reg <= last_next;
      div_tick <= tick_next;
   end
endmodule : ucl_prediv
`default_nettype wire

// >>> src/ucl_sync.sv
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous to mclk
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module ucl_sync #(
   parameter int W = 4
) (
   input  wire logic         mclk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] d_async,
   input  wire logic [W-1:0] rst_val,
   output var  logic [W-1:0] q_sync
);
   // ==========================================================
   // per-bit stages
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic s1_reg;
         logic s1_next;
         logic s2_next;
         always_comb begin
            s1_next = sys_rst ? rst_val[i] : d_async[i];
            s2_next = sys_rst ? rst_val[i] : s1_reg;
         end
         always_ff @(posedge mclk) begin
            s1_reg    <= s1_next;
            q_sync[i] <= s2_next;
         end
      end
   endgenerate
endmodule : ucl_sync
`default_nettype wire
